// file: frc_pkg.sv
/*
  Shared constants for the flash reset, identifier and counter command block:
  timing counts, opcodes, counter-status codes, frame lengths and state codes.
  Assumes a single 200 MHz system clock.
*/
package frc_pkg;
  localparam int CLK_MHZ = 200;
  localparam int RESET_LOW_WIDTH_NS = 1000;
  localparam int RESET_LOW_CYC = (RESET_LOW_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_LOW_W = 8;
  localparam int RECOVERY_TIME_SHORT_US = 30;
  localparam int RECOVERY_SHORT_CYC = RECOVERY_TIME_SHORT_US * CLK_MHZ;
  localparam int RECOVERY_TIME_LONG_MS = 12;
  localparam int RECOVERY_LONG_CYC = RECOVERY_TIME_LONG_MS * 1000 * CLK_MHZ;
  localparam int RECOVERY_W = 22;

  localparam logic [7:0] OP_READ_UNIQUE_IDENT = 8'h4B;
  localparam logic [7:0] OP_READ_PARAM_TABLE = 8'h5A;
  localparam logic [7:0] OP_COUNTER_CMD = 8'h9B;
  localparam logic [7:0] OP_COUNTER_READ = 8'h96;
  localparam logic [7:0] SUB_ROOT_KEY = 8'h00;
  localparam logic [7:0] SUB_UPDATE_KEY = 8'h01;
  localparam logic [7:0] SUB_INCREMENT = 8'h02;
  localparam logic [7:0] SUB_REQUEST = 8'h03;

  localparam logic [7:0] ST_POWER_ON = 8'h00;
  localparam logic [7:0] ST_SUCCESS = 8'h80;
  localparam logic [7:0] ST_BUSY = 8'h01;
  localparam logic [7:0] ST_KEY_ERR = 8'h02;
  localparam logic [7:0] ST_CMD_ERR = 8'h04;
  localparam logic [7:0] ST_UNINIT = 8'h08;
  localparam logic [7:0] ST_DATA_ERR = 8'h10;

  localparam int NUM_COUNTERS = 4;
  localparam logic [6:0] LEN_ROOT_KEY = 7'd64;
  localparam logic [6:0] LEN_UPDATE_KEY = 7'd40;
  localparam logic [6:0] LEN_INCREMENT = 7'd40;
  localparam logic [6:0] LEN_REQUEST = 7'd48;
  localparam logic [6:0] LEN_MAX = 7'd127;
  localparam logic [6:0] UID_START_BYTE = 7'd5;
  localparam logic [6:0] PARAM_START_BYTE = 7'd5;
  localparam logic [6:0] HDR_BYTES = 7'd4;
  localparam int PAYLOAD_BITS = 480;
  localparam int MC_STREAM_BITS = 392;
  localparam logic [8:0] MC_LAST_BIT = 9'd391;
  localparam logic [4:0] HLEN_4 = 5'd4;
  localparam logic [4:0] HLEN_8 = 5'd8;
  localparam logic [4:0] HLEN_16 = 5'd16;

  typedef enum logic [3:0] {
    FRC_EX_IDLE = 4'h1,
    FRC_EX_CHECK = 4'h2,
    FRC_EX_HASH1 = 4'h4,
    FRC_EX_HASH2 = 4'h8
  } frc_exec_t;
endpackage

// file: frc_timer.sv
/*
  Down-counting recovery timer: busy for exactly load_value cycles after load.
  Assumes load_value is at least one when loaded.
*/
`timescale 1ns/10ps
`default_nettype none
module frc_timer #(
  parameter int W = 22
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  output logic busy
);
  import frc_pkg::*;
  logic [W-1:0] count;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign busy = (count != '0);

  a_load_busy: assert property (@(posedge clk_sys) disable iff (reset)
    load && (load_value > 1) |=> busy [*1] ##1 busy)
    else $error("timer not busy after load");
  a_count_steps: assert property (@(posedge clk_sys) disable iff (reset)
    busy && !load |=> count == $past(count) - 1'b1)
    else $error("timer did not count down by one");
endmodule
`default_nettype wire

// file: frc_spi_shift.sv
/*
  Serial front end: edge detection on the serial clock and chip select,
  byte assembly from the serial input on rising clock edges (mode 0/3).
  Assumes the pins are already synchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module frc_spi_shift (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic sclk_fall,
  output logic sel_begin,
  output logic sel_end
);
  import frc_pkg::*;
  logic sclk_q;
  logic cs_q;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  wire sclk_rise = sclk & ~sclk_q & ~cs_n;

  assign sclk_fall = ~sclk & sclk_q & ~cs_n;
  assign sel_begin = cs_q & ~cs_n;
  assign sel_end = ~cs_q & cs_n;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || cs_n) begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= sclk_rise && (bit_cnt == 3'h7);
      if (sclk_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        shift <= {shift[5:0], si};
        if (bit_cnt == 3'h7) begin
          rx_byte <= {shift, si};
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: frc_cmd_core.sv
/*
  Command core: hardware reset pin, recovery timing, unique identifier read,
  parameter-table read and the monotonic-counter command set with its status.
  Assumes an external keyed-hash engine (HMAC-SHA-256) on the hash_* ports, a
  zero-latency parameter-table memory on param_addr/param_data and an array
  engine that reports its running operation on op_in_progress.
*/
//
// Function
// - pin held low for the minimum width resets the device to standby
// - hardware reset returns all volatile bits to power-on defaults
// - hardware reset aborts a running program or erase at once
// - serial output stays high impedance while reset is in progress
// - ready within 30 us after release in the ordinary case
// - recovery up to 12 ms after an interrupted erase or register write
// - fixed read-only 128-bit identifier, different per device
// - opcode 4Bh, four dummy bytes, then identifier bits until select rises
// - opcode 5Ah, three address bytes, one dummy, then table bytes stream
// - sub-command 00h programs the addressed one-time root key
// - four counters, each with root key and volatile hash key
// - root-key write checked by 224-bit truncated keyed hash of header
// - all-ones root key is temporary (here it is locked like any other key); uninitialized counter becomes zero
// - each counter sub-command records an 8-bit status read with 96h
// - sub-command 01h derives hash key from root key over key seed
// - update-key checked by 256-bit signature with the new key
// - sub-command 02h adds one; signature covers current counter value
// - sub-command 03h carries a 96-bit tag signed with the hash key
// - after busy clears, 96h returns tag, counter and signature
// - status 80h marks success; only then are returned fields valid
// - while busy, 96h repeats the status byte until select rises
`timescale 1ns/10ps
`default_nettype none
module frc_cmd_core #(
  parameter logic [frc_pkg::RECOVERY_W-1:0] RECOVERY_SHORT_CYCLES =
    frc_pkg::RECOVERY_W'(frc_pkg::RECOVERY_SHORT_CYC),
  parameter logic [frc_pkg::RECOVERY_W-1:0] RECOVERY_LONG_CYCLES =
    frc_pkg::RECOVERY_W'(frc_pkg::RECOVERY_LONG_CYC),
  parameter logic [127:0] UNIQUE_IDENT = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic so,
  output logic so_oe,
  output logic ready,
  output logic volatile_clear,
  output logic op_abort,
  input wire logic op_in_progress,
  input wire logic op_long_recovery,
  output logic [23:0] param_addr,
  input wire logic [7:0] param_data,
  output logic hash_start,
  output logic [255:0] hash_key,
  output logic [127:0] hash_msg,
  output logic [4:0] hash_len,
  input wire logic hash_done,
  input wire logic [255:0] hash_digest,
  output logic [7:0] counter_status
);
  import frc_pkg::*;

  // unique identifier value is arbitrary
  logic [RESET_LOW_W-1:0] low_cnt;
  logic hw_reset_active;
  logic long_rec;
  logic por_pending;
  logic rec_busy;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic sclk_fall;
  logic sel_begin;
  logic sel_end;
  logic sel_ok;
  logic [7:0] opcode;
  logic [6:0] byte_cnt;
  logic [8:0] out_ptr;
  logic rd_busy;
  logic [7:0] rx_sub;
  logic [7:0] rx_caddr;
  logic [7:0] rx_rsv;
  logic [PAYLOAD_BITS-1:0] payload;
  logic [6:0] ex_len;
  frc_exec_t ex_state;
  logic [255:0] tmp_key;
  logic [95:0] resp_tag;
  logic [31:0] resp_ctr;
  logic [255:0] resp_sig;
  logic [255:0] root_key [NUM_COUNTERS];
  logic root_set [NUM_COUNTERS];
  logic [255:0] hmac_key [NUM_COUNTERS];
  logic hmac_valid [NUM_COUNTERS];
  logic [31:0] counter [NUM_COUNTERS];
  logic counter_init [NUM_COUNTERS];

  function automatic logic [6:0] frame_len(input logic [7:0] sub);
    case (sub)
      SUB_ROOT_KEY: frame_len = LEN_ROOT_KEY;
      SUB_UPDATE_KEY: frame_len = LEN_UPDATE_KEY;
      SUB_INCREMENT: frame_len = LEN_INCREMENT;
      default: frame_len = LEN_REQUEST;
    endcase
  endfunction

  frc_spi_shift u_shift (
    .clk_sys(clk_sys),
    .reset(reset),
    .cs_n(cs_n),
    .sclk(sclk),
    .si(si),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .sclk_fall(sclk_fall),
    .sel_begin(sel_begin),
    .sel_end(sel_end)
  );

  // hardware reset pin: width filter, abort and recovery
  wire hw_rst_hit = ~reset_pin_n && (low_cnt == RESET_LOW_W'(RESET_LOW_CYC - 1));
  wire hw_release = hw_reset_active & reset_pin_n;
  wire rec_load = hw_release | por_pending;
  wire [RECOVERY_W-1:0] rec_value = (hw_release && long_rec) ?
    RECOVERY_LONG_CYCLES : RECOVERY_SHORT_CYCLES;
  wire dev_reset = reset | hw_rst_hit;

  always_ff @(posedge clk_sys) begin
    if (reset || reset_pin_n) begin
      low_cnt <= '0;
    end else if (low_cnt != RESET_LOW_W'(RESET_LOW_CYC)) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hw_reset_active <= 1'b0;
      long_rec <= 1'b0;
      por_pending <= 1'b1;
      op_abort <= 1'b0;
      volatile_clear <= 1'b0;
    end else begin
      por_pending <= 1'b0;
      op_abort <= hw_rst_hit & op_in_progress;
      volatile_clear <= hw_rst_hit;
      if (hw_rst_hit) begin
        hw_reset_active <= 1'b1;
        long_rec <= op_in_progress & op_long_recovery;
      end else if (reset_pin_n) begin
        hw_reset_active <= 1'b0;
      end
    end
  end

  frc_timer #(
    .W(RECOVERY_W)
  ) u_recovery (
    .clk_sys(clk_sys),
    .reset(reset),
    .load(rec_load),
    .load_value(rec_value),
    .busy(rec_busy)
  );

  assign ready = ~rec_busy & ~hw_reset_active & ~por_pending & ~rec_load;

  // command framing
  wire frame_go = ready & reset_pin_n;
  wire mc_accept = sel_ok && (opcode == OP_COUNTER_CMD) && (ex_state == FRC_EX_IDLE);
  wire out_active = sel_ok && ~cs_n && (
    ((opcode == OP_READ_UNIQUE_IDENT) && (byte_cnt >= UID_START_BYTE)) ||
    ((opcode == OP_READ_PARAM_TABLE) && (byte_cnt >= PARAM_START_BYTE)) ||
    ((opcode == OP_COUNTER_READ) && (byte_cnt != 7'd0)));
  wire [MC_STREAM_BITS-1:0] mc_stream = {counter_status, resp_tag, resp_ctr, resp_sig};
  wire uid_bit = UNIQUE_IDENT[7'd127 - out_ptr[6:0]];
  wire param_bit = param_data[3'd7 - out_ptr[2:0]];
  wire status_bit = counter_status[3'd7 - out_ptr[2:0]];
  wire mc_bit = (out_ptr <= MC_LAST_BIT) ? mc_stream[MC_LAST_BIT - out_ptr] : 1'b0;
  wire read_bit = rd_busy ? status_bit : mc_bit;
  wire next_so = (opcode == OP_READ_UNIQUE_IDENT) ? uid_bit :
    (opcode == OP_READ_PARAM_TABLE) ? param_bit : read_bit;

  always_ff @(posedge clk_sys) begin
    if (dev_reset) begin
      sel_ok <= 1'b0;
      opcode <= 8'h00;
      byte_cnt <= 7'd0;
      out_ptr <= 9'd0;
      rd_busy <= 1'b0;
      so <= 1'b0;
      param_addr <= 24'h000000;
    end else if (sel_begin) begin
      sel_ok <= frame_go;
      byte_cnt <= 7'd0;
      out_ptr <= 9'd0;
      so <= 1'b0;
    end else begin
      if (rx_valid && sel_ok) begin
        if (byte_cnt != LEN_MAX) begin
          byte_cnt <= byte_cnt + 7'd1;
        end
        if (byte_cnt == 7'd0) begin
          opcode <= rx_byte;
          rd_busy <= counter_status[0];
        end
        if ((opcode == OP_READ_PARAM_TABLE) && (byte_cnt >= 7'd1) && (byte_cnt <= 7'd3)) begin
          param_addr <= {param_addr[15:0], rx_byte};
        end
      end
      if (sclk_fall && out_active) begin
        so <= next_so;
        out_ptr <= out_ptr + 9'd1;
        if ((opcode == OP_READ_PARAM_TABLE) && (out_ptr[2:0] == 3'h7)) begin
          param_addr <= param_addr + 24'h000001;
        end
      end
      if (cs_n) begin
        so <= 1'b0;
      end
    end
  end

  assign so_oe = out_active & reset_pin_n & ~hw_reset_active;

  // counter command capture, frozen while a command executes
  always_ff @(posedge clk_sys) begin
    if (dev_reset) begin
      rx_sub <= 8'h00;
      rx_caddr <= 8'h00;
      rx_rsv <= 8'h00;
      payload <= '0;
    end else if (rx_valid && mc_accept) begin
      if (byte_cnt == 7'd1) begin
        rx_sub <= rx_byte;
      end
      if (byte_cnt == 7'd2) begin
        rx_caddr <= rx_byte;
      end
      if (byte_cnt == 7'd3) begin
        rx_rsv <= rx_byte;
      end
      if (byte_cnt >= HDR_BYTES) begin
        payload <= {payload[PAYLOAD_BITS-9:0], rx_byte};
      end
    end
  end

  // field views and checks
  wire [1:0] idx = rx_caddr[1:0];
  wire addr_bad = (rx_caddr >= 8'(NUM_COUNTERS));
  wire size_bad = (ex_len != frame_len(rx_sub));
  wire [31:0] header = {OP_COUNTER_CMD, rx_sub, rx_caddr, rx_rsv};
  wire [255:0] new_root = payload[479:224];
  wire [223:0] short_signature = payload[223:0];
  wire [31:0] key_seed = payload[287:256];
  wire [31:0] counter_data = payload[287:256];
  wire [95:0] req_tag = payload[351:256];
  wire [255:0] signature = payload[255:0];
  wire sig_match = (hash_digest == signature);
  wire keys_ready = hmac_valid[idx] & counter_init[idx];
  wire [7:0] err_root = (addr_bad | root_set[idx]) ? ST_KEY_ERR :
    (size_bad ? ST_CMD_ERR : 8'h00);
  wire [7:0] err_upd = (addr_bad | size_bad) ? ST_CMD_ERR :
    (~root_set[idx] ? ST_KEY_ERR : 8'h00);
  wire [7:0] err_use = (addr_bad | size_bad) ? ST_CMD_ERR :
    (~keys_ready ? ST_UNINIT : 8'h00);
  wire [7:0] chk_err = (rx_sub == SUB_ROOT_KEY) ? err_root :
    (rx_sub == SUB_UPDATE_KEY) ? err_upd :
    ((rx_sub == SUB_INCREMENT) || (rx_sub == SUB_REQUEST)) ? err_use : ST_CMD_ERR;
  wire ex_start = sel_end && mc_accept && (byte_cnt >= 7'd2);
  wire root_ok = (ex_state == FRC_EX_HASH1) && hash_done && (rx_sub == SUB_ROOT_KEY) &&
    (hash_digest[255:32] == short_signature);
  wire inc_ok = (ex_state == FRC_EX_HASH1) && hash_done && (rx_sub == SUB_INCREMENT) &&
    sig_match && (counter_data == counter[idx]);
  wire upd_ok = (ex_state == FRC_EX_HASH2) && hash_done && (rx_sub == SUB_UPDATE_KEY) &&
    sig_match;

  // execution sequencer and counter status
  always_ff @(posedge clk_sys) begin
    if (dev_reset) begin
      ex_state <= FRC_EX_IDLE;
      ex_len <= 7'd0;
      counter_status <= ST_POWER_ON;
      hash_start <= 1'b0;
      hash_key <= '0;
      hash_msg <= '0;
      hash_len <= 5'd0;
      tmp_key <= '0;
      resp_tag <= '0;
      resp_ctr <= '0;
      resp_sig <= '0;
    end else begin
      hash_start <= 1'b0;
      case (ex_state)
        FRC_EX_IDLE: begin
          if (ex_start) begin
            ex_len <= byte_cnt;
            counter_status <= ST_BUSY;
            ex_state <= FRC_EX_CHECK;
          end
        end
        FRC_EX_CHECK: begin
          if (chk_err != 8'h00) begin
            counter_status <= chk_err;
            ex_state <= FRC_EX_IDLE;
          end else begin
            hash_start <= 1'b1;
            ex_state <= FRC_EX_HASH1;
            case (rx_sub)
              SUB_ROOT_KEY: begin
                hash_key <= new_root;
                hash_msg <= {header, 96'h0};
                hash_len <= HLEN_4;
              end
              SUB_UPDATE_KEY: begin
                hash_key <= root_key[idx];
                hash_msg <= {key_seed, 96'h0};
                hash_len <= HLEN_4;
              end
              SUB_INCREMENT: begin
                hash_key <= hmac_key[idx];
                hash_msg <= {header, counter_data, 64'h0};
                hash_len <= HLEN_8;
              end
              default: begin
                hash_key <= hmac_key[idx];
                hash_msg <= {header, req_tag};
                hash_len <= HLEN_16;
              end
            endcase
          end
        end
        FRC_EX_HASH1: begin
          if (hash_done) begin
            ex_state <= FRC_EX_IDLE;
            case (rx_sub)
              SUB_ROOT_KEY: begin
                counter_status <= root_ok ? ST_SUCCESS : ST_KEY_ERR;
              end
              SUB_UPDATE_KEY: begin
                tmp_key <= hash_digest;
                hash_start <= 1'b1;
                hash_key <= hash_digest;
                hash_msg <= {header, key_seed, 64'h0};
                hash_len <= HLEN_8;
                ex_state <= FRC_EX_HASH2;
              end
              SUB_INCREMENT: begin
                counter_status <= ~sig_match ? ST_CMD_ERR :
                  (inc_ok ? ST_SUCCESS : ST_DATA_ERR);
              end
              default: begin
                if (sig_match) begin
                  resp_tag <= req_tag;
                  resp_ctr <= counter[idx];
                  hash_start <= 1'b1;
                  hash_msg <= {req_tag, counter[idx]};
                  hash_len <= HLEN_16;
                  ex_state <= FRC_EX_HASH2;
                end else begin
                  counter_status <= ST_CMD_ERR;
                end
              end
            endcase
          end
        end
        FRC_EX_HASH2: begin
          if (hash_done) begin
            ex_state <= FRC_EX_IDLE;
            if (rx_sub == SUB_UPDATE_KEY) begin
              counter_status <= upd_ok ? ST_SUCCESS : ST_CMD_ERR;
            end else begin
              resp_sig <= hash_digest;
              counter_status <= ST_SUCCESS;
            end
          end
        end
        default: begin
          ex_state <= FRC_EX_IDLE;
        end
      endcase
    end
  end

  // key and counter storage; root keys and counters survive the pin reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        root_key[i] <= '0;
        root_set[i] <= 1'b0;
        counter[i] <= 32'h00000000;
        counter_init[i] <= 1'b0;
      end
    end else begin
      if (root_ok) begin
        root_key[idx] <= new_root;
        root_set[idx] <= 1'b1;
        if (!counter_init[idx]) begin
          counter[idx] <= 32'h00000000;
          counter_init[idx] <= 1'b1;
        end
      end
      if (inc_ok) begin
        counter[idx] <= counter[idx] + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (dev_reset) begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        hmac_key[i] <= '0;
        hmac_valid[i] <= 1'b0;
      end
    end else if (upd_ok) begin
      hmac_key[idx] <= tmp_key;
      hmac_valid[idx] <= 1'b1;
    end
  end

  a_so_quiet_reset: assert property (@(posedge clk_sys) disable iff (reset)
    !reset_pin_n |-> !so_oe)
    else $error("serial output driven during reset");
  a_reset_min_width: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(hw_reset_active) |-> $past(low_cnt) == 8'd199 && !$past(reset_pin_n))
    else $error("reset taken before minimum width");
  a_abort_follows: assert property (@(posedge clk_sys) disable iff (reset)
    hw_rst_hit && op_in_progress |=> op_abort && volatile_clear)
    else $error("running operation not aborted");
  a_clear_follows: assert property (@(posedge clk_sys) disable iff (reset)
    hw_rst_hit |=> volatile_clear && counter_status == 8'h00)
    else $error("volatile state not cleared");
  a_not_ready_release: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(hw_reset_active) |-> !ready [*8])
    else $error("ready too early after release");
  a_long_recovery: assert property (@(posedge clk_sys) disable iff (reset)
    hw_release && long_rec |-> rec_value == RECOVERY_LONG_CYCLES)
    else $error("long recovery not selected");
  a_busy_status: assert property (@(posedge clk_sys) disable iff (reset)
    ex_state != FRC_EX_IDLE |-> counter_status == 8'h01)
    else $error("status not busy while executing");
  a_success_code: assert property (@(posedge clk_sys) disable iff (reset)
    inc_ok || root_ok |=> counter_status == 8'h80 && ex_state == FRC_EX_IDLE)
    else $error("success status missing");
  a_counter_plus_one: assert property (@(posedge clk_sys) disable iff (reset)
    inc_ok |=> counter[$past(idx)] == $past(counter[idx]) + 32'h00000001)
    else $error("counter not incremented by one");
  a_root_once: assert property (@(posedge clk_sys) disable iff (reset)
    ex_state == FRC_EX_CHECK && rx_sub == 8'h00 && root_set[idx] && !addr_bad
    |=> counter_status == 8'h02)
    else $error("root key overwrite not refused");
endmodule
`default_nettype wire

// file: frc_hash_model.sv
/* stand-in keyed-hash engine and parameter-table memory for frc_cmd_core.
   assumes one hash request in flight; the digest is a cheap mix. */
`timescale 1ns/10ps
`default_nettype none
module frc_hash_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hash_start,
  input wire logic [255:0] hash_key,
  input wire logic [127:0] hash_msg,
  input wire logic [4:0] hash_len,
  input wire logic [23:0] param_addr,
  output logic hash_done,
  output logic [255:0] hash_digest,
  output logic [7:0] param_data
);
  logic [2:0] pipe;
  logic [255:0] dig;
  logic [127:0] msg;
  assign msg = hash_msg & ~({128{1'b1}} >> (8 * hash_len));
  assign param_data = param_addr[7:0] ^ 8'hA5;
  assign hash_done = pipe[2];
  // digest only valid in the done cycle
  assign hash_digest = hash_done ? dig : ~dig;
  always_ff @(posedge clk_sys) begin
    pipe <= reset ? 3'h0 : {pipe[1:0], hash_start};
    if (hash_start) begin
      dig <= {hash_key[127:0] ^ msg, hash_key[255:128]};
    end
  end
endmodule
`default_nettype wire

// file: frc_cmd_core_test.sv
/* self-checking bench for frc_cmd_core.
   assumes frc_hash_model as hash engine and table memory. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,g) begin checks++; if ((g)!==(e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module frc_cmd_core_test;
  import frc_pkg::*;
  localparam int SH = 20;
  localparam int LG = 40;
  localparam logic [127:0] UID = 128'hC3A5_9E71_0B2D_4F68_1A3C_5E70_92B4_D6F8; // arbitrary
  logic clk_sys = 0, reset = 1, pin_n = 1, cs_n = 1, sclk = 0, si = 0, op_ip = 0, op_lg = 0;
  logic so, so_oe, ready, vclr, abrt, hs, hd;
  logic [23:0] pa;
  logic [7:0] pd, st, r;
  logic [255:0] hk, dg, d;
  logic [127:0] hm;
  logic [4:0] hl;
  logic [479:0] pl;
  int miscompares = 0, checks = 0, n, vc = 0, ab = 0;
  frc_cmd_core #(.RECOVERY_SHORT_CYCLES(22'(SH)), .RECOVERY_LONG_CYCLES(22'(LG)),
    .UNIQUE_IDENT(UID)) DUT (.clk_sys(clk_sys), .reset(reset), .reset_pin_n(pin_n),
    .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe), .ready(ready),
    .volatile_clear(vclr), .op_abort(abrt), .op_in_progress(op_ip),
    .op_long_recovery(op_lg), .param_addr(pa), .param_data(pd), .hash_start(hs),
    .hash_key(hk), .hash_msg(hm), .hash_len(hl), .hash_done(hd), .hash_digest(dg),
    .counter_status(st));
  frc_hash_model PM (.clk_sys(clk_sys), .reset(reset), .hash_start(hs), .hash_key(hk),
    .hash_msg(hm), .hash_len(hl), .param_addr(pa), .hash_done(hd), .hash_digest(dg),
    .param_data(pd));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    if (vclr === 1'b1) vc++;
    if (abrt === 1'b1) ab++;
  end
  task automatic tally_and_finish(input bit hung);
    if (hung) miscompares++;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic xb(input logic [7:0] o, output logic [7:0] i);
    cs_n = 0;
    for (int b = 7; b >= 0; b--) begin
      sclk = 0;
      si = o[b];
      repeat (3) @(negedge clk_sys);
      i[b] = so;
      sclk = 1;
      repeat (3) @(negedge clk_sys);
    end
  endtask
  task automatic fin;
    sclk = 0;
    repeat (3) @(negedge clk_sys);
    cs_n = 1;
    n = 0;
    while ((n < 8 || st === ST_BUSY) && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 500) tally_and_finish(1);
  endtask
  task automatic wr;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 5000) tally_and_finish(1);
  endtask
  task automatic cmd(input logic [7:0] s, a, e, input int len);
    xb(OP_COUNTER_CMD, r);
    xb(s, r);
    xb(a, r);
    xb(8'h00, r);
    for (int k = 0; k < len; k++) xb(pl[479-8*k -: 8], r);
    fin;
    `CHK("status", e, st)
    xb(OP_COUNTER_READ, r);
    xb(8'h00, r);
    fin;
    `CHK("read_96", e, r)
  endtask
  task automatic pr(input int w);
    pin_n = 0;
    repeat (w) @(negedge clk_sys);
    `CHK("so_oe", 1'b0, so_oe)
    pin_n = 1;
    repeat (4) @(negedge clk_sys);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    tally_and_finish(1);
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    reset = 0;
    wr;
    `CHK("short_rec", 1'b1, n <= SH + 4)
    `CHK("st_por", ST_POWER_ON, st)
    xb(OP_READ_UNIQUE_IDENT, r);
    repeat (4) xb(8'h00, r);
    for (int k = 15; k >= 0; k--) begin
      xb(8'h00, r);
      `CHK("uid", UID[8*k +: 8], r)
    end
    fin;
    xb(OP_READ_PARAM_TABLE, r);
    xb(8'h00, r);
    xb(8'h00, r);
    xb(8'h10, r);
    xb(8'h00, r);
    for (int k = 0; k < 3; k++) begin
      xb(8'h00, r);
      `CHK("table", 8'(8'h10 + k) ^ 8'hA5, r)
    end
    fin;
    $display("test reads done");
    cmd(8'h04, 8'h01, ST_CMD_ERR, 0);
    cmd(8'hFF, 8'h01, ST_CMD_ERR, 0);
    d = {~{OP_COUNTER_CMD, SUB_ROOT_KEY, 8'h01, 8'h00, 96'h0}, {128{1'b1}}};
    pl = {{256{1'b1}}, d[255:32]};
    cmd(SUB_ROOT_KEY, 8'h01, ST_SUCCESS, 60);
    cmd(SUB_ROOT_KEY, 8'h01, ST_KEY_ERR, 60);
    cmd(SUB_ROOT_KEY, 8'h07, ST_KEY_ERR, 60);
    d = {~{OP_COUNTER_CMD, SUB_UPDATE_KEY, 8'h01, 8'h00, 32'h5A5A0001, 64'h0},
      ~{32'h5A5A0001, 96'h0}};
    pl = {32'h5A5A0001, d, 192'h0};
    cmd(SUB_UPDATE_KEY, 8'h01, ST_SUCCESS, 36);
    d = {~{OP_COUNTER_CMD, SUB_INCREMENT, 8'h01, 8'h00, 32'h0, 64'h0}, ~{32'h5A5A0001, 96'h0}};
    pl = {32'h0, d, 192'h0};
    cmd(SUB_INCREMENT, 8'h01, ST_SUCCESS, 36);
    cmd(SUB_INCREMENT, 8'h01, ST_DATA_ERR, 36);
    $display("test counter done");
    op_ip = 1;
    op_lg = 1;
    pr(RESET_LOW_CYC);
    op_ip = 0;
    `CHK("clear", 1, vc)
    `CHK("abort", 1, ab)
    `CHK("not_ready", 1'b0, ready)
    `CHK("st_clr", ST_POWER_ON, st)
    wr;
    `CHK("long_rec", 1'b1, n > SH + 4)
    repeat (RESET_LOW_CYC) @(negedge clk_sys);
    cmd(SUB_INCREMENT, 8'h01, ST_UNINIT, 36);
    pr(50);
    `CHK("short_pulse", 1, vc)
    $display("test pin reset done");
    tally_and_finish(0);
  end
endmodule
`default_nettype wire
